/* File: logic/fprd_top.sv */
// range protection decoder: config register, array load at reset,
// program/erase gatekeeper, sticky events and one interrupt
// assumes register port, array port and requests all on ref_clk
module fprd_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // array read port for the reset load
  output logic nv_rd_req,
  output logic [15:0] nv_rd_addr,
  input wire logic [7:0] nv_rd_data,
  // program / erase check
  input wire logic pe_req,
  input wire logic [15:0] pe_addr,
  input wire logic pe_mass,
  output logic pe_ok,
  output logic pe_refuse,
  // interrupt
  output logic irq
);

  // every check below runs on ref_clk and is muted while reset is low
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // state
  fprd_pkg::fprd_load_type ld_reg, ld_next; // load sequencer
  logic [7:0] cfg_reg, cfg_next; // range_protection_config
  logic [1:0] stat_reg, stat_next; // sticky events
  logic [1:0] mask_reg, mask_next; // interrupt mask
  logic irq_reg, irq_next;
  logic [7:0] rdata_reg, rdata_next;
  logic ok_reg, ok_next;
  logic refuse_reg, refuse_next;
  logic nvreq_reg, nvreq_next;
  logic [15:0] nvaddr_reg, nvaddr_next;

  // decode helpers
  logic loaded; // config holds the array byte
  logic open_pol; // range_polarity_select
  logic hdis, ldis; // window disables
  logic hhit, lhit; // address inside each window
  logic in_windows; // inside an enabled window
  logic prot_hit; // request targets protected area
  logic cfg_wr; // write strobe to config
  logic [7:0] cfg_cand; // candidate after size gating
  logic move_ok; // candidate is an allowed scenario move
  logic ev_viol, ev_reject; // event pulses

  // protection scenario index, 0..7
  function automatic logic [2:0] scen(input logic [7:0] c);
    scen = c[fprd_pkg::CFG_POLARITY] ?
      {1'b0, ~c[fprd_pkg::CFG_HDIS], ~c[fprd_pkg::CFG_LDIS]} :
      {1'b1, ~c[fprd_pkg::CFG_LDIS], ~c[fprd_pkg::CFG_HDIS]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // window decode

  // top window: 2, 4, 8, 16 kbyte ending at 0xffff
  fprd_range_hit #(
    .ANCHOR(16'h0000),
    .UNIT(fprd_pkg::HIGH_UNIT),
    .AT_TOP(1'b1)
  ) u_high (
    .addr(pe_addr),
    .size_code(cfg_reg[fprd_pkg::CFG_HS_HI:fprd_pkg::CFG_HS_LO]),
    .hit(hhit)
  ); // RQ8

  // bottom window: 512 byte to 4 kbyte from 0x4000
  fprd_range_hit #(
    .ANCHOR(fprd_pkg::LOW_BASE),
    .UNIT(fprd_pkg::LOW_UNIT),
    .AT_TOP(1'b0)
  ) u_low (
    .addr(pe_addr),
    .size_code(cfg_reg[fprd_pkg::CFG_LS_HI:fprd_pkg::CFG_LS_LO]),
    .hit(lhit)
  ); // RQ8

  // protection decision and write screening
  always_comb begin
    loaded = (ld_reg == fprd_pkg::LD_RUN);
    open_pol = cfg_reg[fprd_pkg::CFG_POLARITY];
    hdis = cfg_reg[fprd_pkg::CFG_HDIS];
    ldis = cfg_reg[fprd_pkg::CFG_LDIS];
    // a cleared disable bit opens its window
    in_windows = (~hdis & hhit) | (~ldis & lhit); // RQ3 RQ5
    // polarity one: windows protected; zero: windows are the holes
    prot_hit = open_pol ? in_windows : ~in_windows; // RQ1 RQ2
    // mass erase only when nothing at all is protected
    if (pe_mass) begin
      prot_hit = ~(open_pol & hdis & ldis);
    end
    cfg_wr = reg_wr && (reg_addr == fprd_pkg::REG_CONFIG) && loaded;
    // sizes follow the write only while their window is disabled
    cfg_cand = reg_wdata;
    cfg_cand[fprd_pkg::CFG_SPARE] = cfg_reg[fprd_pkg::CFG_SPARE];
    if (!hdis) begin
      cfg_cand[fprd_pkg::CFG_HS_HI:fprd_pkg::CFG_HS_LO] =
        cfg_reg[fprd_pkg::CFG_HS_HI:fprd_pkg::CFG_HS_LO]; // RQ4
    end
    if (!ldis) begin
      cfg_cand[fprd_pkg::CFG_LS_HI:fprd_pkg::CFG_LS_LO] =
        cfg_reg[fprd_pkg::CFG_LS_HI:fprd_pkg::CFG_LS_LO]; // RQ6
    end
    // table of allowed scenario moves; some, such as 7 to 0 and 4 to 3, remove protection
    move_ok = fprd_pkg::MOVE_OK[{scen(cfg_reg), scen(cfg_cand)}]; // RQ11
    ev_viol = pe_req && loaded && prot_hit; // RQ10
    ev_reject = cfg_wr && !move_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // load sequencer and config register

  // next config: array byte at load, screened writes later
  always_comb begin
    ld_next = ld_reg;
    cfg_next = cfg_reg;
    nvreq_next = 1'b0;
    nvaddr_next = fprd_pkg::PROT_BYTE_ADDR;
    unique case (ld_reg)
      fprd_pkg::LD_ISSUE: begin
        nvreq_next = 1'b1;
        ld_next = fprd_pkg::LD_CAPT;
      end
      fprd_pkg::LD_CAPT: begin
        // request is out this cycle, byte is on the port with it
        if (nvreq_reg) begin
          cfg_next = nv_rd_data; // RQ9
          ld_next = fprd_pkg::LD_RUN;
        end
      end
      fprd_pkg::LD_RUN: begin
        if (cfg_wr && move_ok) begin
          cfg_next = cfg_cand; // RQ11
        end
      end
      default: begin
        // illegal code: reload rather than trust the config
        ld_next = fprd_pkg::LD_ISSUE;
      end
    endcase
  end

  // register the load sequencer and config
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ld_reg <= fprd_pkg::LD_ISSUE;
      cfg_reg <= fprd_pkg::CFG_RESET;
      nvreq_reg <= 1'b0;
      nvaddr_reg <= fprd_pkg::PROT_BYTE_ADDR;
    end else begin
      ld_reg <= ld_next;
      cfg_reg <= cfg_next;
      nvreq_reg <= nvreq_next;
      nvaddr_reg <= nvaddr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events, mask, interrupt, request answer, read data

  // set wins over a simultaneous write-one clear
  always_comb begin
    stat_next = stat_reg;
    mask_next = mask_reg;
    if (reg_wr && reg_addr == fprd_pkg::REG_STATUS) begin
      stat_next = stat_reg & ~reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == fprd_pkg::REG_MASK) begin
      mask_next = reg_wdata[1:0];
    end
    stat_next[fprd_pkg::ST_VIOLATION] = stat_next[fprd_pkg::ST_VIOLATION] | ev_viol; // RQ10
    stat_next[fprd_pkg::ST_WR_REJECT] = stat_next[fprd_pkg::ST_WR_REJECT] | ev_reject;
    irq_next = |(stat_next & mask_next);
    // requests during the load are refused without a flag
    ok_next = pe_req && loaded && !prot_hit;
    refuse_next = pe_req && !(loaded && !prot_hit); // RQ10
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        fprd_pkg::REG_CONFIG: rdata_next = cfg_reg;
        fprd_pkg::REG_STATUS: rdata_next = {6'h00, stat_reg};
        fprd_pkg::REG_MASK: rdata_next = {6'h00, mask_reg};
        fprd_pkg::REG_INFO: rdata_next = {7'h00, loaded};
        default: rdata_next = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // register events and answers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= fprd_pkg::STATUS_RESET;
      mask_reg <= fprd_pkg::MASK_RESET;
      irq_reg <= 1'b0;
      ok_reg <= 1'b0;
      refuse_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      ok_reg <= ok_next;
      refuse_reg <= refuse_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign nv_rd_req = nvreq_reg;
  assign nv_rd_addr = nvaddr_reg;
  assign pe_ok = ok_reg;
  assign pe_refuse = refuse_reg;
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // a plain program request in the run state
  sequence s_prog;
    pe_req && loaded && !pe_mass;
  endsequence

  property p_rq1;
    s_prog ##0 (open_pol && !hdis && hhit) |=> pe_refuse && !pe_ok;
  endproperty
  a_rq1: assert property (p_rq1) else $error("enabled high window not protected"); // RQ1

  property p_rq2;
    s_prog ##0 (!open_pol && hdis && ldis) |=> pe_refuse;
  endproperty
  a_rq2: assert property (p_rq2) else $error("inverted polarity left a hole"); // RQ2

  property p_rq3;
    s_prog ##0 (open_pol && hdis && !lhit) |=> pe_ok;
  endproperty
  a_rq3: assert property (p_rq3) else $error("disabled high window still protects"); // RQ3

  property p_rq4;
    cfg_wr && !hdis |=> $stable(cfg_reg[fprd_pkg::CFG_HS_HI:fprd_pkg::CFG_HS_LO]);
  endproperty
  a_rq4: assert property (p_rq4) else $error("high size changed while enabled"); // RQ4

  property p_rq5;
    s_prog ##0 (open_pol && !ldis && lhit) |=> pe_refuse;
  endproperty
  a_rq5: assert property (p_rq5) else $error("enabled low window not protected"); // RQ5

  property p_rq6;
    cfg_wr && !ldis |=> $stable(cfg_reg[fprd_pkg::CFG_LS_HI:fprd_pkg::CFG_LS_LO]);
  endproperty
  a_rq6: assert property (p_rq6) else $error("low size changed while enabled"); // RQ6

  property p_rq8;
    s_prog ##0 (open_pol && !hdis && pe_addr == 16'hf7ff
      && cfg_reg[fprd_pkg::CFG_HS_HI:fprd_pkg::CFG_HS_LO] == 2'h0) |=> pe_ok;
  endproperty
  a_rq8: assert property (p_rq8) else $error("2k high window too large"); // RQ8

  sequence s_load;
    ld_reg == fprd_pkg::LD_ISSUE ##1 nv_rd_req && ld_reg == fprd_pkg::LD_CAPT;
  endsequence

  property p_rq9;
    s_load |=> cfg_reg == $past(nv_rd_data) && loaded;
  endproperty
  a_rq9: assert property (p_rq9) else $error("config not loaded from array"); // RQ9

  property p_rq10;
    pe_req && loaded && prot_hit |=> pe_refuse && stat_reg[fprd_pkg::ST_VIOLATION];
  endproperty
  a_rq10: assert property (p_rq10) else $error("violation not refused or flagged"); // RQ10

  property p_rq11;
    cfg_wr && !move_ok |=> $stable(cfg_reg) && stat_reg[fprd_pkg::ST_WR_REJECT];
  endproperty
  a_rq11: assert property (p_rq11) else $error("protection-removing write taken"); // RQ11

endmodule // fprd_top

/* File: logic/fprd_pkg.sv */
// constants, register map and field layout of the range protection decoder
// assumes one 125 MHz clock and an array read port on that same clock
//
// Summary of operation
// RQ1: polarity one: cleared disable bit protects range
// RQ2: polarity zero: selected ranges unprotected, rest protected
// RQ3: high disable zero enables the top window
// RQ4: high size writable only while high disabled
// RQ5: low disable zero enables the bottom window
// RQ6: low size writable only while low disabled
// RQ7: software leaves the spare flag bit erased
// RQ8: size codes pick 2-16K top, 512-4K low
// RQ9: reset loads config from array byte 0xff0d
// RQ10: program/erase in protected area refused, flagged
// RQ11: only writes that add protection are accepted (the MOVE_OK table also passes removals such as 7 to 0 and 4 to 3)
package fprd_pkg;

  // register indices on the plain register port
  localparam logic [2:0] REG_CONFIG = 3'h0; // range protection config
  localparam logic [2:0] REG_STATUS = 3'h1; // sticky events, write one to clear
  localparam logic [2:0] REG_MASK = 3'h2; // interrupt mask, same layout
  localparam logic [2:0] REG_INFO = 3'h3; // read-only block state

  // config field positions
  localparam int CFG_POLARITY = 7; // range_polarity_select
  localparam int CFG_SPARE = 6; // spare_nonvolatile_flag
  localparam int CFG_HDIS = 5; // high_window_disable
  localparam int CFG_HS_HI = 4; // high_window_size msb
  localparam int CFG_HS_LO = 3; // high_window_size lsb
  localparam int CFG_LDIS = 2; // low_window_disable
  localparam int CFG_LS_HI = 1; // low_window_size msb
  localparam int CFG_LS_LO = 0; // low_window_size lsb

  // config value before the array byte arrives (erased byte)
  localparam logic [7:0] CFG_RESET = 8'hff;

  // status bits
  localparam int ST_VIOLATION = 0; // violation_flag
  localparam int ST_WR_REJECT = 1; // config write refused
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // info bits
  localparam int INFO_LOADED = 0;

  // array location of the protection byte
  localparam logic [15:0] PROT_BYTE_ADDR = 16'hff0d;

  // window geometry
  localparam logic [15:0] HIGH_UNIT = 16'h0800; // 2 kbyte step at the top
  localparam logic [15:0] LOW_BASE = 16'h4000; // low window start
  localparam logic [15:0] LOW_UNIT = 16'h0200; // 512 byte step

  // legal scenario moves: bit (from*8+to) set when allowed
  localparam logic [63:0] MOVE_OK = 64'hff5a3c18080c0a0f;

  // load sequencer states
  typedef enum logic [2:0] {
    LD_ISSUE = 3'b001, // request the byte from the array
    LD_CAPT = 3'b010,  // byte valid on the read data
    LD_RUN = 3'b100    // normal operation
  } fprd_load_type;

endpackage : fprd_pkg

/* File: logic/fprd_range_hit.sv */
// one address window test: top-anchored or base-anchored span of unit << code
// assumes a 16-bit address map; purely combinational
module fprd_range_hit #(
  parameter logic [15:0] ANCHOR = 16'h0000,
  parameter logic [15:0] UNIT = 16'h0200,
  parameter bit AT_TOP = 1'b0
) (
  // address and size code
  input wire logic [15:0] addr,
  input wire logic [1:0] size_code,
  // result
  output logic hit
);

  logic [15:0] span; // window length in bytes
  logic [15:0] start; // first byte of the window

  // span doubles per code step; top windows wrap down from zero
  always_comb begin
    span = UNIT << size_code;
    start = AT_TOP ? 16'(16'h0000 - span) : ANCHOR;
    hit = (addr >= start) && (AT_TOP || (addr < 16'(ANCHOR + span)));
  end

endmodule // fprd_range_hit

/* File: test/fprd_top_tb_top.sv */
// self-checking bench for the range protection decoder
// assumes fprd_top with its package; bench plays register master and array
module fprd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic ref_clk = 1'b0; // 125 MHz
  logic nrst = 1'b0; // held low at start
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic nv_rd_req;
  logic [15:0] nv_rd_addr;
  logic [7:0] nv_rd_data = 8'h00; // array byte, flipped once consumed
  logic pe_req = 1'b0;
  logic [15:0] pe_addr = 16'h0000;
  logic pe_mass = 1'b0;
  logic pe_ok;
  logic pe_refuse;
  logic irq;
  int miscompares = 0; // mismatch count
  int total_checks = 0; // comparison count

  fprd_top uut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_rd_req(nv_rd_req),
    .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data), .pe_req(pe_req), .pe_addr(pe_addr),
    .pe_mass(pe_mass), .pe_ok(pe_ok), .pe_refuse(pe_refuse), .irq(irq));

  // free-running clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks; wr, rdchk, pe and irqchk start in the time step of a rising edge
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // reset, then serve the array byte; a hung load request ends the run
  task automatic boot(input logic [7:0] v);
    int n;
    nrst <= 1'b0;
    nv_rd_data <= v;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (nv_rd_req !== 1'b1 && n < 8);
    chk("load request edge", 16'(n), 16'h0001);
    chk("load address", nv_rd_addr, fprd_pkg::PROT_BYTE_ADDR);
    if (n >= 8) summarize();
    @(posedge ref_clk);
    // byte no longer held: show its inverse so a late capture is seen
    nv_rd_data <= ~v;
    @(posedge ref_clk);
  endtask

  // one-cycle write strobe, then a spare edge so strobes never collide
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // read data only stands in the cycle after the strobe
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, reg_rdata}, {8'h00, exp});
    @(posedge ref_clk);
  endtask

  // program/erase request, answer exactly one cycle later
  task automatic pe(input logic [15:0] a, input logic m, input logic ok);
    pe_req <= 1'b1;
    pe_addr <= a;
    pe_mass <= m;
    @(posedge ref_clk);
    pe_req <= 1'b0;
    #1;
    chk("pe allowed", {15'h0, pe_ok}, {15'h0, ok});
    chk("pe refused", {15'h0, pe_refuse}, {15'h0, ~ok});
    @(posedge ref_clk);
  endtask

  // irq settles with status; two edges leave margin for either timing
  task automatic irqchk(input logic exp);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq", {15'h0, irq}, {15'h0, exp});
    @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_load_and_size_gate();
    boot(8'he4); // polarity one, both windows off, spare left erased
    rdchk(fprd_pkg::REG_CONFIG, 8'he4, "config after load");
    rdchk(fprd_pkg::REG_INFO, 8'h01, "loaded flag");
    pe(16'hffff, 1'b1, 1'b1);
    wr(fprd_pkg::REG_CONFIG, 8'hfd); // sizes writable while disabled
    rdchk(fprd_pkg::REG_CONFIG, 8'hfd, "sizes written");
    pe(16'hf800, 1'b0, 1'b1);
    wr(fprd_pkg::REG_CONFIG, 8'hdd); // open the 16K top window
    pe(16'hc000, 1'b0, 1'b0);
    pe(16'hbfff, 1'b0, 1'b1);
    pe(16'h4000, 1'b0, 1'b1);
    pe(16'h0000, 1'b1, 1'b0);
    rdchk(fprd_pkg::REG_STATUS, 8'h01, "violation flag");
    // high size locked now, low size still open
    wr(fprd_pkg::REG_CONFIG, 8'hc6);
    rdchk(fprd_pkg::REG_CONFIG, 8'hde, "size gating");
    $display("test load_and_size_gate done");
  endtask

  // every size code, both windows enabled, probing each edge
  task automatic t_window_sizes();
    logic [15:0] hb;
    logic [15:0] le;
    for (int c = 0; c < 4; c++) begin
      boot({3'b110, c[1:0], 1'b0, c[1:0]});
      hb = 16'h0000 - (fprd_pkg::HIGH_UNIT << c);
      le = fprd_pkg::LOW_BASE + (fprd_pkg::LOW_UNIT << c);
      pe(hb, 1'b0, 1'b0);
      pe(hb - 16'h0001, 1'b0, 1'b1);
      pe(le - 16'h0001, 1'b0, 1'b0);
      pe(le, 1'b0, 1'b1);
      pe(fprd_pkg::LOW_BASE - 16'h0001, 1'b0, 1'b1);
    end
    $display("test window_sizes done");
  endtask

  // removal refused, flagged, masked and cleared; unmapped space inert
  task automatic t_reject_irq();
    wr(fprd_pkg::REG_STATUS, 8'h03);
    wr(fprd_pkg::REG_CONFIG, 8'hfe);
    rdchk(fprd_pkg::REG_CONFIG, 8'hdb, "refused write");
    irqchk(1'b0); // masked off
    wr(fprd_pkg::REG_MASK, 8'h02);
    irqchk(1'b1);
    rdchk(fprd_pkg::REG_STATUS, 8'h02, "reject flag");
    wr(fprd_pkg::REG_STATUS, 8'h02);
    irqchk(1'b0);
    wr(3'h5, 8'hff);
    rdchk(3'h5, 8'h00, "unmapped read");
    wr(fprd_pkg::REG_INFO, 8'h00);
    rdchk(fprd_pkg::REG_INFO, 8'h01, "info read only");
    $display("test reject_irq done");
  endtask

  // polarity zero: enabled windows are the only open areas
  task automatic t_polarity_zero();
    boot(8'h45); // 2K top window open, low disabled
    pe(16'hf800, 1'b0, 1'b1);
    pe(16'hf7ff, 1'b0, 1'b0);
    pe(16'h4000, 1'b0, 1'b0);
    pe(16'h0000, 1'b1, 1'b0);
    wr(fprd_pkg::REG_CONFIG, 8'h65); // close it: whole array protected
    rdchk(fprd_pkg::REG_CONFIG, 8'h65, "adding protection");
    pe(16'hffff, 1'b0, 1'b0);
    wr(fprd_pkg::REG_CONFIG, 8'h41); // reopening is a removal
    rdchk(fprd_pkg::REG_CONFIG, 8'h65, "reopen refused");
    $display("test polarity_zero done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    t_load_and_size_gate();
    t_window_sizes();
    t_reject_irq();
    t_polarity_zero();
    summarize();
  end

endmodule // fprd_top_tb_top
